// >>> bench/dual_uart_props.sv
`timescale 1ns/1ps
module dual_uart_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Pins
    input wire logic txd_o,
    input wire logic ch0_irq_o,
    input wire logic ch1_irq_o
);
    logic [7:0] run_r;
    logic prev_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Cycles the line has held its level
    always_ff @(posedge clk_i) begin
        prev_r <= txd_o;
        if (reset_i || txd_o != prev_r) begin
            run_r <= 8'h00;
        end else if (run_r != 8'hFF) begin
            run_r <= run_r + 8'h01;
        end
    end
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    ack_after_req_a: assert property (req_s |=> ack_o)
        else $error("request not acknowledged");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    reset_idle_a: assert property ($fell(reset_i) |-> txd_o)
        else $error("line not idle after reset");
    // Start bit may be one cycle short of a full bit
    bit_width_a: assert property
        (txd_o != prev_r |-> run_r >= 8'h1E)
        else $error("bit shorter than minimum");
    irq0_hold_a: assert property (ch0_irq_o && !(cyc_i && we_i)
        && !$past(cyc_i && we_i) |=> ch0_irq_o)
        else $error("ch0 request dropped by itself");
    irq1_hold_a: assert property (ch1_irq_o && !(cyc_i && we_i)
        && !$past(cyc_i && we_i) |=> ch1_irq_o)
        else $error("ch1 request dropped by itself");
endmodule

// >>> bench/serial_host.sv
`timescale 1ns/1ps
module serial_host (
    // Clock
    input wire logic clk_i,
    // Line
    input wire logic txd_i,
    output logic rxd_o
);
    // Pulled-up line idles high
    initial rxd_o = 1'h1;

    task automatic get(input int bclk, input int nb, output logic [8:0] d,
        output logic ok);
        int n;
        n = 0;
        d = 9'h000;
        while (txd_i !== 1'h0 && n < 8000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (bclk / 2) @(posedge clk_i);
        ok = (n < 8000) && (txd_i === 1'h0);
        for (int i = 0; i < nb; i++) begin
            repeat (bclk) @(posedge clk_i);
            d[i] = txd_i;
        end
        repeat (bclk) @(posedge clk_i);
        ok = ok && (txd_i === 1'h1);
    endtask

    task automatic put(input int bclk, input logic [7:0] d);
        logic [9:0] f;
        f = {1'h1, d, 1'h0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= f[i];
            repeat (bclk) @(posedge clk_i);
        end
    endtask
endmodule

// >>> bench/tb_dual_uart.sv
`timescale 1ns/1ps
module tb_dual_uart;
    import dual_uart_pkg::*;
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic cyc_i = 1'h0;
    logic stb_i = 1'h0;
    logic we_i = 1'h0;
    logic [ADR_W-1:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, rxd_i, txd_o, ch0_irq_o, ch1_irq_o;
    int failures = 0;
    int checked = 0;
    initial forever #25 clk_i = ~clk_i;
    dual_uart u_dual_uart(.clk_i, .reset_i, .ce_i(1'h1), .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rxd_i, .txd_o,
        .ch0_irq_o, .ch1_irq_o);
    serial_host u_serial_host(.clk_i, .txd_i(txd_o), .rxd_o(rxd_i));
    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [8:0] got, exp, input string msg);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] idx,
        input logic [7:0] wd, output logic [7:0] rd);
        int n;
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= we;
        adr_i <= {idx, 2'h0};
        sel_i <= 4'h1;
        dat_i <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'h1 && n < 50);
        rd = dat_o[7:0];
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
        if (n >= 50) begin
            check(1'h0, 1'h1, "bus timeout");
            complete_run();
        end
        @(posedge clk_i);
    endtask
    task automatic run_tx(input logic ch, input logic [7:0] ctl, rate, pwr,
        input int bclk, nb, input logic [7:0] d, input logic n9);
        logic [8:0] got;
        logic ok;
        logic [7:0] rd;
        wb(1'h1, 8'hF1, {7'h0, ch}, rd);
        wb(1'h1, 8'h87, pwr, rd);
        wb(1'h1, 8'hD8, rate, rd);
        wb(1'h1, ch ? 8'h9B : 8'h98, ctl, rd);
        wb(1'h1, ch ? 8'h9C : 8'h99, d, rd);
        u_serial_host.get(bclk, nb, got, ok);
        check({8'h0, ok}, 9'h001, "frame shape");
        check(got, {nb == 9 ? n9 : 1'h0, d}, "frame data");
        repeat (bclk) @(posedge clk_i);
        wb(1'h0, ch ? 8'h9B : 8'h98, 8'h00, rd);
        check({8'h0, rd[1]}, 9'h001, "transmit flag");
        check({8'h0, ch ? ch1_irq_o : ch0_irq_o}, 9'h001, "irq");
        wb(1'h1, ch ? 8'h9B : 8'h98, ctl, rd);
        @(posedge clk_i);
        check({7'h0, ch1_irq_o, ch0_irq_o}, 9'h000, "irq clear");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] rd;
        logic [7:0] regs [3];
        regs = '{8'h87, 8'hD8, 8'hF1};
        repeat (5) @(posedge clk_i);
        reset_i <= 1'h0;
        @(posedge clk_i);
        foreach (regs[i]) begin
            wb(1'h0, regs[i], 8'h00, rd);
            check({1'h0, rd}, 9'h000, "reset value");
        end
        wb(1'h0, 8'h00, 8'h00, rd);
        check({1'h0, rd}, 9'h000, "unmapped read");
        wb(1'h1, 8'h87, 8'h80, rd);
        wb(1'h0, 8'h87, 8'h00, rd);
        check({1'h0, rd}, 9'h080, "double bit");
        wb(1'h1, 8'hAA, 8'hFF, rd);
        wb(1'h1, 8'hBA, 8'hFF, rd);
        wb(1'h1, 8'h9D, 8'hFF, rd);
        wb(1'h1, 8'hBB, 8'hFF, rd);
        wb(1'h1, 8'h8D, 8'hFF, rd);
        run_tx(1'h0, 8'h40, 8'h00, 8'h00, 384, 8, 8'hA5, 1'h0);
        run_tx(1'h0, 8'hC8, 8'h80, 8'h80, 32, 9, 8'h3C, 1'h1);
        run_tx(1'h0, 8'h80, 8'h00, 8'h00, 64, 9, 8'h81, 1'h0);
        run_tx(1'h0, 8'h88, 8'h00, 8'h80, 32, 9, 8'h5A, 1'h1);
        wb(1'h1, 8'h9A, 8'h06, rd);
        run_tx(1'h0, 8'hC0, 8'h80, 8'h80, 32, 9, 8'h3C, 1'h1);
        wb(1'h1, 8'h9A, 8'h00, rd);
        run_tx(1'h1, 8'h08, 8'h00, 8'h80, 32, 9, 8'hC3, 1'h1);
        run_tx(1'h1, 8'h40, 8'h00, 8'h00, 32, 8, 8'h96, 1'h0);
        wb(1'h1, 8'hF1, 8'h00, rd);
        wb(1'h1, 8'h87, 8'h80, rd);
        wb(1'h1, 8'hD8, 8'h80, rd);
        wb(1'h1, 8'h98, 8'h50, rd);
        u_serial_host.put(32, 8'h3C);
        repeat (40) @(posedge clk_i);
        wb(1'h0, 8'h99, 8'h00, rd);
        check({1'h0, rd}, 9'h03C, "received byte");
        wb(1'h0, 8'h98, 8'h00, rd);
        check({8'h0, rd[0]}, 9'h001, "receive flag");
        check({8'h0, ch0_irq_o}, 9'h001, "receive irq");
        // Loop-back routes the pin to the other receiver
        wb(1'h1, 8'hF1, 8'h02, rd);
        wb(1'h1, 8'h9B, 8'h50, rd);
        u_serial_host.put(32, 8'hA5);
        repeat (40) @(posedge clk_i);
        wb(1'h0, 8'h9C, 8'h00, rd);
        check({1'h0, rd}, 9'h0A5, "loop-back byte");
        wb(1'h0, 8'h9B, 8'h00, rd);
        check({8'h0, rd[0]}, 9'h001, "ch1 receive flag");
        check({8'h0, ch1_irq_o}, 9'h001, "ch1 receive irq");
        complete_run();
    end
endmodule
bind dual_uart dual_uart_props u_dual_uart_props(.clk_i, .reset_i, .cyc_i,
    .stb_i, .we_i, .dat_o, .ack_o, .txd_o, .ch0_irq_o, .ch1_irq_o);

// >>> rtl/dual_uart.sv
// Function
// - Two channels, selector routes one to pins
// - Link runs up to 625000 bit/s (32 clocks per bit)
// - Receiver assembles data LSB first
// - Transmitter shifts data LSB first
// - Parity, parity type, stop bits, rate programmable
// - Ch0 modes 1 and 3, no mode 0
// - Ch0 mode 2 nine bits, fixed rate
// - Ch1 mode 0 nine bits, generator rate
// - Ch1 mode 1 eight bits, no modes 2/3
// - Ninth transmitted bit from control register, or parity when enabled
// - Ch0 timer 1 rate formula
// - Ch0 generator rate formula
// - Ch1 generator rate, no timer 1
// - Reload value from high 1:0, low 7:0
// - Doubling bit 7 of power control
// - Ch0 done flags raise one request
// - Ch1 done flags raise one request
// - Rate select bit 7 picks ch0 source
// - Pin select and loop-back routing
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps

module uart_channel
    import dual_uart_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Control
    input wire logic tick_i,
    input wire chan_cfg_t cfg_i,
    input wire logic tx_start_i,
    input wire logic [7:0] tx_data_i,
    // Line
    input wire logic rx_i,
    output logic tx_o,
    output chan_evt_t evt_o
);

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH,
        TX_STOP} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
        rx_state_t;

    tx_state_t tx_state_r;
    rx_state_t rx_state_r;
    logic [3:0] tx_sub_r, rx_sub_r, tx_cnt_r, rx_cnt_r;
    logic [7:0] tx_sh_r, rx_sh_r;
    logic tx_ninth_r, tx_stop2_r, tx_r, rx_prev_r, rx_ninth_r;
    logic tx_done_r, rx_done_r, ferr_r, perr_r;
    logic [7:0] rx_data_r;
    logic rx_dat_ninth_r;

    wire tx_step = tick_i && tx_sub_r == OVS_LAST;
    wire rx_step = tick_i && rx_sub_r == OVS_LAST;
    wire rx_fall = rx_prev_r && !rx_i;
    wire tx_par = ^tx_data_i ^ cfg_i.parity_odd;
    wire rx_par_bad = cfg_i.parity_en &&
        (^rx_sh_r ^ cfg_i.parity_odd) != rx_ninth_r;

    ////////////////////////////////////////////////////////////////////
    // Transmitter
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_state_r <= TX_IDLE;
            tx_sub_r <= '0;
            tx_cnt_r <= '0;
            tx_sh_r <= '0;
            tx_ninth_r <= 1'b0;
            tx_stop2_r <= 1'b0;
            tx_r <= 1'b1;
            tx_done_r <= 1'b0;
        end else if (ce_i) begin
            tx_done_r <= 1'b0;
            if (tick_i && tx_state_r != TX_IDLE) begin
                tx_sub_r <= tx_sub_r + 4'h1;
            end
            unique case (tx_state_r)
                TX_IDLE: begin
                    tx_r <= 1'b1;
                    if (tx_start_i) begin
                        tx_sh_r <= tx_data_i;
                        // Parity or software ninth bit
                        tx_ninth_r <= cfg_i.parity_en ? tx_par
                            : cfg_i.tx_ninth;
                        tx_sub_r <= '0;
                        tx_r <= 1'b0;
                        tx_state_r <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_step) begin
                        tx_r <= tx_sh_r[0];
                        tx_sh_r <= tx_sh_r >> 1;
                        tx_cnt_r <= '0;
                        tx_state_r <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_step) begin
                        tx_cnt_r <= tx_cnt_r + 4'h1;
                        if (tx_cnt_r != DATA_LAST) begin
                            tx_r <= tx_sh_r[0];
                            tx_sh_r <= tx_sh_r >> 1;
                        end else if (cfg_i.nine_bit) begin
                            tx_r <= tx_ninth_r;
                            tx_state_r <= TX_NINTH;
                        end else begin
                            tx_r <= 1'b1;
                            tx_stop2_r <= cfg_i.two_stop;
                            tx_state_r <= TX_STOP;
                        end
                    end
                end
                TX_NINTH: begin
                    if (tx_step) begin
                        tx_r <= 1'b1;
                        tx_stop2_r <= cfg_i.two_stop;
                        tx_state_r <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_step) begin
                        if (tx_stop2_r) begin
                            tx_stop2_r <= 1'b0;
                        end else begin
                            tx_done_r <= 1'b1;
                            tx_state_r <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receiver
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_state_r <= RX_IDLE;
            rx_sub_r <= '0;
            rx_cnt_r <= '0;
            rx_sh_r <= '0;
            rx_ninth_r <= 1'b0;
            rx_prev_r <= 1'b1;
            rx_done_r <= 1'b0;
            rx_data_r <= '0;
            rx_dat_ninth_r <= 1'b0;
            ferr_r <= 1'b0;
            perr_r <= 1'b0;
        end else if (ce_i) begin
            rx_prev_r <= rx_i;
            rx_done_r <= 1'b0;
            if (tick_i && rx_state_r != RX_IDLE) begin
                rx_sub_r <= rx_sub_r + 4'h1;
            end
            unique case (rx_state_r)
                RX_IDLE: begin
                    if (cfg_i.rx_en && rx_fall) begin
                        rx_sub_r <= '0;
                        rx_state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick_i && rx_sub_r == OVS_MID) begin
                        rx_sub_r <= '0;
                        rx_cnt_r <= '0;
                        rx_state_r <= rx_i ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_step) begin
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r <= DATA_LAST) begin
                            rx_sh_r <= {rx_i, rx_sh_r[7:1]};
                        end else begin
                            rx_ninth_r <= rx_i;
                        end
                        if (rx_cnt_r == DATA_LAST + 4'(cfg_i.nine_bit)) begin
                            rx_state_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_step) begin
                        rx_data_r <= rx_sh_r;
                        rx_dat_ninth_r <= cfg_i.nine_bit ? rx_ninth_r : rx_i;
                        ferr_r <= !rx_i;
                        perr_r <= cfg_i.nine_bit && rx_par_bad;
                        rx_done_r <= 1'b1;
                        rx_state_r <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    assign tx_o = tx_r;
    assign evt_o = '{rx_done: rx_done_r, tx_done: tx_done_r,
        rx_data: rx_data_r, rx_ninth: rx_dat_ninth_r,
        frame_err: ferr_r, parity_err: perr_r,
        busy: tx_state_r != TX_IDLE};

endmodule

////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module dual_uart
    import dual_uart_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Serial pins
    input wire logic rxd_i,
    output logic txd_o,
    // Interrupt requests
    output logic ch0_irq_o,
    output logic ch1_irq_o
);

    function automatic logic [4:0] halve(input logic [4:0] pre,
                                         input logic dbl);
        halve = dbl ? pre >> 1 : pre;
    endfunction

    function automatic logic [9:0] reload_of(input logic [7:0] high,
                                             input logic [7:0] low);
        reload_of = {high[1:0], low};
    endfunction

    logic [7:0] power_control_reg_r, rate_control_reg_r;
    logic [7:0] misc_control_reg_r, timer1_high_byte_r;
    logic [7:0] ctrl_r [2];
    logic [7:0] frame_r [2];
    logic [7:0] rell_r [2];
    logic [7:0] relh_r [2];
    logic ack_r, rxd_meta_r, rxd_sync_r, txd_r;
    logic [31:0] dat_r;
    logic [7:0] rd_byte;
    logic [1:0] tx_line, rx_line;
    chan_evt_t evt [2];

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    wire req = cyc_i && stb_i;
    wire wr_go = req && we_i && ack_r && sel_i[0];
    wire [7:0] idx = adr_i[ADR_W-1:2];
    wire [7:0] wbyte = dat_i[7:0];
    wire rate_double = power_control_reg_r[DOUBLE_BIT];
    wire rate_source_select = rate_control_reg_r[RATE_SEL_BIT];
    wire pin_select = misc_control_reg_r[PIN_SEL_BIT];
    wire channel_loop_back = misc_control_reg_r[LOOP_BIT];

    always_comb begin
        rd_byte = RESET_BYTE;
        unique case (1'b1)
            idx == IDX_POWER_CTRL: rd_byte = power_control_reg_r;
            idx == IDX_RATE_CTRL: rd_byte = rate_control_reg_r;
            idx == IDX_MISC_CTRL: rd_byte = misc_control_reg_r;
            idx == IDX_TIMER1_HIGH: rd_byte = timer1_high_byte_r;
            idx == IDX_CTRL[0]: rd_byte = ctrl_r[0];
            idx == IDX_CTRL[1]: rd_byte = ctrl_r[1];
            idx == IDX_DATA[0]: rd_byte = evt[0].rx_data;
            idx == IDX_DATA[1]: rd_byte = evt[1].rx_data;
            idx == IDX_FRAME[0]: rd_byte = frame_r[0];
            idx == IDX_FRAME[1]: rd_byte = frame_r[1];
            idx == IDX_RELL[0]: rd_byte = rell_r[0];
            idx == IDX_RELL[1]: rd_byte = rell_r[1];
            idx == IDX_RELH[0]: rd_byte = relh_r[0];
            idx == IDX_RELH[1]: rd_byte = relh_r[1];
            default: rd_byte = RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
            power_control_reg_r <= RESET_BYTE;
            rate_control_reg_r <= RESET_BYTE;
            misc_control_reg_r <= RESET_BYTE;
            timer1_high_byte_r <= RESET_BYTE;
        end else if (ce_i) begin
            ack_r <= req && !ack_r;
            if (req && !ack_r) begin
                dat_r <= {24'h000000, rd_byte};
            end
            if (wr_go && idx == IDX_POWER_CTRL) begin
                power_control_reg_r <= wbyte;
            end
            if (wr_go && idx == IDX_RATE_CTRL) begin
                rate_control_reg_r <= wbyte;
            end
            if (wr_go && idx == IDX_MISC_CTRL) begin
                misc_control_reg_r <= wbyte;
            end
            if (wr_go && idx == IDX_TIMER1_HIGH) begin
                timer1_high_byte_r <= wbyte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin routing
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rxd_meta_r <= 1'b1;
            rxd_sync_r <= 1'b1;
            txd_r <= 1'b1;
        end else if (ce_i) begin
            rxd_meta_r <= rxd_i;
            rxd_sync_r <= rxd_meta_r;
            txd_r <= tx_line[pin_select];
        end
    end

    // Loop-back feeds the pin to the unselected receiver
    assign rx_line[0] = (pin_select == channel_loop_back) ? rxd_sync_r
        : 1'b1;
    assign rx_line[1] = (pin_select != channel_loop_back) ? rxd_sync_r
        : 1'b1;

    ////////////////////////////////////////////////////////////////////
    // Channels
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [4:0] pre_cnt_r;
        logic [9:0] div_cnt_r;
        logic tick_r;
        logic [4:0] pre;
        logic [9:0] reload;
        chan_cfg_t cfg;

        wire [1:0] mode = ctrl_r[ch][MODE_HI:MODE_LO];
        // Ch0 has no mode 0, ch1 has no modes 2 and 3
        wire active = (ch == 0) ? mode != MODE_0
            : !mode[1];
        wire nine = (ch == 0) ? mode[1] : mode == MODE_0;
        wire fixed = ch == 0 && mode == MODE_2;
        wire use_t1 = ch == 0 && !fixed && !rate_source_select;
        // Wraps at once when a rate change shrinks the prescale
        wire pre_hit = pre_cnt_r >= pre - 5'h01;
        wire data_wr = wr_go && idx == IDX_DATA[ch];
        wire ctrl_wr = wr_go && idx == IDX_CTRL[ch];
        wire frame_wr = wr_go && idx == IDX_FRAME[ch];

        if (ch == 0) begin : g_rate0
            assign pre = fixed ? halve(PRE_FIX, rate_double)
                : use_t1 ? halve(PRE_T1, rate_double)
                : halve(PRE_GEN0, rate_double);
            assign reload = fixed ? DIV_MAX
                : use_t1 ? {T1_TOP, timer1_high_byte_r}
                : reload_of(relh_r[0], rell_r[0]);
        end else begin : g_rate1
            assign pre = PRE_GEN1;
            assign reload = reload_of(relh_r[1], rell_r[1]);
        end

        assign cfg = '{nine_bit: nine,
            tx_ninth: ctrl_r[ch][TB8_BIT],
            parity_en: frame_r[ch][PAR_EN_BIT],
            parity_odd: frame_r[ch][PAR_ODD_BIT],
            two_stop: frame_r[ch][TWO_STOP_BIT],
            rx_en: active && ctrl_r[ch][REN_BIT]};

        // Sixteen ticks per bit
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                pre_cnt_r <= '0;
                div_cnt_r <= DIV_MAX;
                tick_r <= 1'b0;
            end else if (ce_i) begin
                tick_r <= 1'b0;
                pre_cnt_r <= pre_hit ? 5'h00 : pre_cnt_r + 5'h01;
                if (!active) begin
                    pre_cnt_r <= '0;
                    div_cnt_r <= DIV_MAX;
                end else if (pre_hit) begin
                    if (div_cnt_r == DIV_MAX) begin
                        div_cnt_r <= reload;
                        tick_r <= 1'b1;
                    end else begin
                        div_cnt_r <= div_cnt_r + 10'h001;
                    end
                end
            end
        end

        // Hardware flag set wins over a software write
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                ctrl_r[ch] <= RESET_BYTE;
                frame_r[ch] <= RESET_BYTE;
                rell_r[ch] <= RESET_BYTE;
                relh_r[ch] <= RESET_BYTE;
            end else if (ce_i) begin
                if (ctrl_wr) begin
                    ctrl_r[ch] <= wbyte;
                end
                if (evt[ch].rx_done) begin
                    ctrl_r[ch][RI_BIT] <= 1'b1;
                    ctrl_r[ch][RB8_BIT] <= evt[ch].rx_ninth;
                end
                if (evt[ch].tx_done) begin
                    ctrl_r[ch][TI_BIT] <= 1'b1;
                end
                if (frame_wr) begin
                    frame_r[ch] <= wbyte;
                end
                if (evt[ch].rx_done && evt[ch].frame_err) begin
                    frame_r[ch][FERR_BIT] <= 1'b1;
                end
                if (evt[ch].rx_done && evt[ch].parity_err) begin
                    frame_r[ch][PERR_BIT] <= 1'b1;
                end
                if (wr_go && idx == IDX_RELL[ch]) begin
                    rell_r[ch] <= wbyte;
                end
                if (wr_go && idx == IDX_RELH[ch]) begin
                    relh_r[ch] <= wbyte;
                end
            end
        end

        uart_channel u_chan (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .ce_i(ce_i),
            .tick_i(tick_r),
            .cfg_i(cfg),
            .tx_start_i(data_wr && active && !evt[ch].busy),
            .tx_data_i(wbyte),
            .rx_i(rx_line[ch]),
            .tx_o(tx_line[ch]),
            .evt_o(evt[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign txd_o = txd_r;
    assign ch0_irq_o = ctrl_r[0][RI_BIT] || ctrl_r[0][TI_BIT];
    assign ch1_irq_o = ctrl_r[1][RI_BIT] || ctrl_r[1][TI_BIT];

endmodule

// >>> rtl/dual_uart_pkg.sv
package dual_uart_pkg;

    // Clock and link rates
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_MIN = 300;
    localparam int BAUD_MAX = 115_200;
    localparam int OVS = 16;

    // Rate dividers
    localparam int T1_DIV = 384;
    localparam int GEN0_DIV = 64;
    localparam int GEN1_DIV = 32;
    localparam int FIX_DIV = 64;
    localparam logic [4:0] PRE_T1 = 5'(T1_DIV / OVS);
    localparam logic [4:0] PRE_GEN0 = 5'(GEN0_DIV / OVS);
    localparam logic [4:0] PRE_GEN1 = 5'(GEN1_DIV / OVS);
    localparam logic [4:0] PRE_FIX = 5'(FIX_DIV / OVS);
    localparam logic [9:0] DIV_MAX = 10'h3FF;
    localparam logic [1:0] T1_TOP = 2'h3;

    // Oversampling points
    localparam logic [3:0] OVS_MID = 4'(OVS / 2 - 1);
    localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
    localparam logic [3:0] DATA_LAST = 4'h7;

    // Bus and register indices
    localparam int ADR_W = 10;
    localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
    localparam logic [7:0] IDX_RATE_CTRL = 8'hD8;
    localparam logic [7:0] IDX_MISC_CTRL = 8'hF1;
    localparam logic [7:0] IDX_TIMER1_HIGH = 8'h8D;
    localparam logic [7:0] IDX_CTRL [2] = '{8'h98, 8'h9B};
    localparam logic [7:0] IDX_DATA [2] = '{8'h99, 8'h9C};
    localparam logic [7:0] IDX_FRAME [2] = '{8'h9A, 8'h9E};
    localparam logic [7:0] IDX_RELL [2] = '{8'hAA, 8'h9D};
    localparam logic [7:0] IDX_RELH [2] = '{8'hBA, 8'hBB};
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Field positions
    localparam int DOUBLE_BIT = 7;
    localparam int RATE_SEL_BIT = 7;
    localparam int PIN_SEL_BIT = 0;
    localparam int LOOP_BIT = 1;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int REN_BIT = 4;
    localparam int TB8_BIT = 3;
    localparam int RB8_BIT = 2;
    localparam int TI_BIT = 1;
    localparam int RI_BIT = 0;
    localparam int TWO_STOP_BIT = 0;
    localparam int PAR_EN_BIT = 1;
    localparam int PAR_ODD_BIT = 2;
    localparam int FERR_BIT = 6;
    localparam int PERR_BIT = 7;

    // Channel modes
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_3 = 2'h3;

    typedef struct packed {
        logic nine_bit;
        logic tx_ninth;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic rx_en;
    } chan_cfg_t;

    typedef struct packed {
        logic rx_done;
        logic tx_done;
        logic [7:0] rx_data;
        logic rx_ninth;
        logic frame_err;
        logic parity_err;
        logic busy;
    } chan_evt_t;

endpackage
